// File: rtl/regfap_access.sv
// regfap_access: access port, lane mapping and policy words of the register bank
// Overview of operation
// (R1) fixed-one fields read all ones and discard writes.
// (R2) fixed-zero fields read all zeros and discard every write.
// (R3) software writes zero, or the value read earlier, to zero-or-preserve fields.
// (R4) software writes ones, or the value read earlier, to one-or-preserve fields.
// (R5) software always writes ones to should-write-one fields.
// (R6) write-one-clear bits read normally; writing 1 clears, 0 keeps.
// (R7) writing back a read value clears only bits set at that read.
// (R8) read-only bits return current value; write data is ignored.
// (R9) reserved bit positions behave as unknown-value, zero-or-preserve fields.
// (R10) such unknown-value fields read zero and ignore writes.
// (R11) every access completes, reserved or not; nothing stalls.
// (R12) little-endian: low address maps to least significant lane.
// (R13) halfword is aligned only at addresses divisible by 2.
// (R14) word is aligned only at addresses divisible by 4.
// (R15) software changes one field by read, modify, write back whole word.
// (R16) byte-lane write enables update only the addressed lanes.
`timescale 1ns/1ps
`default_nettype none
module regfap_access (
  input wire logic clk,
  input wire logic resetn,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [1:0] acc_size,
  input wire logic [regfap_pkg::ADDR_W-1:0] acc_addr,
  input wire logic [regfap_pkg::DATA_W-1:0] acc_wdata,
  input wire logic [regfap_pkg::DATA_W-1:0] hw_set,
  input wire logic [regfap_pkg::DATA_W-1:0] hw_val,
  output logic acc_done,
  output logic acc_misaligned,
  output logic [regfap_pkg::DATA_W-1:0] acc_rdata,
  output logic [regfap_pkg::DATA_W-1:0] ctrl_q,
  output logic [regfap_pkg::DATA_W-1:0] stat_q
);
  import regfap_pkg::*;

  localparam int WIDX_W = ADDR_W - 2;

  // the word decoder picks a slot with three address bits and four byte lanes
  if (NUM_WORDS != 4 || LANES != 4 || DATA_W != 32 || ADDR_W != 5) begin : g_bad_geometry
    $error("regfap_access: package geometry not supported");
  end

  typedef struct packed {
    logic done;
    logic misaligned;
    logic [DATA_W-1:0] rdata;
  } regfap_top_st_t;

  regfap_top_st_t st_q;
  regfap_top_st_t st_d;
  logic aligned;
  logic [1:0] lane;
  logic [4:0] shift;
  logic [LANES-1:0] be;
  logic [DATA_W-1:0] size_mask;
  logic [DATA_W-1:0] wdata_lane;
  logic [DATA_W-1:0] word_rd;
  logic [WIDX_W-1:0] widx;
  logic [DATA_W-1:0] rd_arr [NUM_WORDS];
  logic [DATA_W-1:0] val_arr [NUM_WORDS];
  logic [NUM_WORDS-1:0] we_vec;

  assign lane = acc_addr[1:0];
  assign widx = acc_addr[ADDR_W-1:2];
  assign shift = {lane, 3'h0};

  always_comb begin
    // odd sizes and misaligned addresses still complete, but touch nothing
    case (acc_size)
      SZ_BYTE: begin
        aligned = 1'b1;
        size_mask = BYTE_MASK;
        be = 4'h1 << lane; // see (R12)
      end
      SZ_HALF: begin
        aligned = ~lane[0]; // see (R13)
        size_mask = HALF_MASK;
        be = 4'h3 << lane; // see (R12)
      end
      SZ_WORD: begin
        aligned = (lane == 2'h0); // see (R14)
        size_mask = WORD_MASK;
        be = 4'hF;
      end
      default: begin
        aligned = 1'b0;
        size_mask = WORD_MASK;
        be = 4'h0;
      end
    endcase
    wdata_lane = (acc_wdata & size_mask) << shift; // see (R12)
  end

  for (genvar i = 0; i < NUM_WORDS; i++) begin : g_word
    assign we_vec[i] = acc_valid & acc_write & aligned & (widx == WIDX_W'(i));
    regfap_word #(
      .RW(RW_MASK[i]),
      .W1C(W1C_MASK[i]),
      .RO(RO_MASK[i]),
      .FIXED_ONE(FIXED_ONE_MASK[i]),
      .RST(RESET_VAL[i])
    ) u_word (
      .clk(clk),
      .resetn(resetn),
      .we(we_vec[i]),
      .be(be),
      .wdata(wdata_lane),
      .hw_set(hw_set),
      .hw_val(hw_val),
      .rdata(rd_arr[i]),
      .val_q(val_arr[i])
    );
  end

  // unmapped word slots read zero like reserved bits
  assign word_rd = (widx < WIDX_W'(NUM_WORDS)) ? rd_arr[widx[1:0]] : '0; // see (R9) see (R10)

  always_comb begin
    st_d = st_q;
    st_d.done = acc_valid; // see (R11)
    st_d.misaligned = acc_valid & ~aligned;
    if (acc_valid) begin
      if (!acc_write && aligned) begin
        st_d.rdata = (word_rd >> shift) & size_mask; // see (R12)
      end else begin
        st_d.rdata = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{done: 1'b0, misaligned: 1'b0, rdata: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign acc_done = st_q.done;
  assign acc_misaligned = st_q.misaligned;
  assign acc_rdata = st_q.rdata;
  assign ctrl_q = val_arr[0];
  assign stat_q = val_arr[1];

  property p_fixed_one_reads;
    @(posedge clk) disable iff (!resetn)
    (acc_valid && !acc_write && acc_size == SZ_WORD && acc_addr == CTRL_OFF)
      |=> (acc_rdata[CTRL_ZERO_LSB-1:CTRL_ONE_LSB] == 8'hFF);
  endproperty
  a_fixed_one_reads: assert property (p_fixed_one_reads) // see (R1)
    else $error("fixed-one field did not read ones");

  property p_fixed_zero_reads;
    @(posedge clk) disable iff (!resetn)
    (acc_valid && !acc_write && acc_size == SZ_WORD && acc_addr == CTRL_OFF)
      |=> (acc_rdata[31:CTRL_ZERO_LSB] == 8'h00);
  endproperty
  a_fixed_zero_reads: assert property (p_fixed_zero_reads) // see (R2)
    else $error("fixed-zero field did not read zero");

  property p_rsv_reads_zero;
    @(posedge clk) disable iff (!resetn)
    (acc_valid && !acc_write && acc_addr == RSV_OFF) |=> (acc_rdata == 32'h0000_0000);
  endproperty
  a_rsv_reads_zero: assert property (p_rsv_reads_zero) // see (R9) see (R10)
    else $error("reserved word read nonzero");

  property p_ro_reads_live;
    @(posedge clk) disable iff (!resetn)
    (acc_valid && !acc_write && acc_size == SZ_WORD && acc_addr == HWST_OFF)
      |=> (acc_rdata[15:0] == $past(hw_val[15:0]) && acc_rdata[31:16] == 16'h0000);
  endproperty
  a_ro_reads_live: assert property (p_ro_reads_live) // see (R8)
    else $error("read-only field did not show hardware value");

  property p_always_done;
    @(posedge clk) disable iff (!resetn)
    acc_valid |=> acc_done;
  endproperty
  a_always_done: assert property (p_always_done) // see (R11)
    else $error("access did not complete in one cycle");

  property p_half_odd_misaligned;
    @(posedge clk) disable iff (!resetn)
    (acc_valid && acc_size == SZ_HALF && acc_addr[0]) |=> (acc_misaligned && acc_rdata == '0);
  endproperty
  a_half_odd_misaligned: assert property (p_half_odd_misaligned) // see (R13)
    else $error("odd halfword not flagged misaligned");

  property p_word_misaligned_no_write;
    @(posedge clk) disable iff (!resetn)
    (acc_valid && acc_write && acc_size == SZ_WORD && acc_addr[1:0] != 2'h0)
      |=> (acc_misaligned && ctrl_q == $past(ctrl_q));
  endproperty
  a_word_misaligned_no_write: assert property (p_word_misaligned_no_write) // see (R14)
    else $error("misaligned word write took effect");

  property p_byte_lane_read;
    @(posedge clk) disable iff (!resetn)
    (acc_valid && !acc_write && acc_size == SZ_BYTE && acc_addr == (CTRL_OFF + 5'h01))
      |=> (acc_rdata == {24'h00_0000, $past(ctrl_q[15:8])});
  endproperty
  a_byte_lane_read: assert property (p_byte_lane_read) // see (R12)
    else $error("byte read from wrong lane");

  property p_byte_write_keeps_lanes;
    @(posedge clk) disable iff (!resetn)
    (acc_valid && acc_write && acc_size == SZ_BYTE && acc_addr == CTRL_OFF)
      |=> (ctrl_q[15:8] == $past(ctrl_q[15:8]) && ctrl_q[7:0] == $past(acc_wdata[7:0]));
  endproperty
  a_byte_write_keeps_lanes: assert property (p_byte_write_keeps_lanes) // see (R16)
    else $error("byte write disturbed another lane");

  property p_w1c_clears;
    @(posedge clk) disable iff (!resetn)
    (acc_valid && acc_write && acc_size == SZ_WORD && acc_addr == STAT_OFF && hw_set == '0)
      |=> ((stat_q & $past(acc_wdata)) == 32'h0000_0000);
  endproperty
  a_w1c_clears: assert property (p_w1c_clears) // see (R6)
    else $error("write one did not clear status bit");

  // completion flags are one-cycle pulses, never left standing
  property p_done_pulse;
    @(posedge clk) disable iff (!resetn)
    !acc_valid |=> (!acc_done && !acc_misaligned);
  endproperty
  a_done_pulse: assert property (p_done_pulse) // see (R11)
    else $error("completion flag stood without an access");

  // read data holds between accesses so a slow reader still sees it
  property p_rdata_holds;
    @(posedge clk) disable iff (!resetn)
    !acc_valid |=> (acc_rdata == $past(acc_rdata));
  endproperty
  a_rdata_holds: assert property (p_rdata_holds) // see (R11)
    else $error("read data changed without an access");
endmodule // regfap_access
`default_nettype wire

// File: rtl/regfap_pkg.sv
// regfap_pkg: constants for the register field access policy block
package regfap_pkg;

  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int ADDR_W = 5;
  localparam int NUM_WORDS = 4;

  // byte offsets of the implemented words; slots 0x10..0x1C are unmapped
  localparam logic [ADDR_W-1:0] CTRL_OFF = 5'h00;
  localparam logic [ADDR_W-1:0] STAT_OFF = 5'h04;
  localparam logic [ADDR_W-1:0] HWST_OFF = 5'h08;
  localparam logic [ADDR_W-1:0] RSV_OFF = 5'h0C;

  // access size codes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  localparam logic [DATA_W-1:0] BYTE_MASK = 32'h0000_00FF;
  localparam logic [DATA_W-1:0] HALF_MASK = 32'h0000_FFFF;
  localparam logic [DATA_W-1:0] WORD_MASK = 32'hFFFF_FFFF;

  // per-word field policy, index order: ctrl, stat, hwst, rsv
  // bits in none of the masks, except the ctrl fixed-zero field from CTRL_ZERO_LSB up, are reserved: unknown_value_field, zero_or_preserve_write
  localparam logic [DATA_W-1:0] RW_MASK [NUM_WORDS] = '{
    32'h0000_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  localparam logic [DATA_W-1:0] W1C_MASK [NUM_WORDS] = '{
    32'h0000_0000, 32'h0000_00FF, 32'h0000_0000, 32'h0000_0000};
  localparam logic [DATA_W-1:0] RO_MASK [NUM_WORDS] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_FFFF, 32'h0000_0000};
  // reads_fixed_one, writes_discarded (one_or_preserve_write from software)
  localparam logic [DATA_W-1:0] FIXED_ONE_MASK [NUM_WORDS] = '{
    32'h00FF_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  localparam logic [DATA_W-1:0] RESET_VAL [NUM_WORDS] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  // ctrl field layout
  localparam int CTRL_ONE_LSB = 16;
  localparam int CTRL_ZERO_LSB = 24;

endpackage

// File: rtl/regfap_word.sv
// regfap_word: one 32-bit register word with per-bit access policy
`timescale 1ns/1ps
`default_nettype none
module regfap_word #(
  parameter logic [31:0] RW = 32'h0000_0000,
  parameter logic [31:0] W1C = 32'h0000_0000,
  parameter logic [31:0] RO = 32'h0000_0000,
  parameter logic [31:0] FIXED_ONE = 32'h0000_0000,
  parameter logic [31:0] RST = 32'h0000_0000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic we,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  input wire logic [31:0] hw_set,
  input wire logic [31:0] hw_val,
  output logic [31:0] rdata,
  output logic [31:0] val_q
);
  import regfap_pkg::*;

  // a bit may carry one policy only; a clash would silently merge two behaviours
  localparam logic [31:0] CLASH = (RW & W1C) | (RW & RO) | (RW & FIXED_ONE) | (W1C & RO)
    | (W1C & FIXED_ONE) | (RO & FIXED_ONE);

  if (CLASH != 32'h0000_0000) begin : g_bad_masks
    $error("regfap_word: overlapping field policies");
  end

  typedef struct packed {
    logic [31:0] val;
  } regfap_word_st_t;

  regfap_word_st_t st_q;
  regfap_word_st_t st_d;
  logic [31:0] wmask;
  logic [31:0] rw_new;
  logic [31:0] w1c_new;

  always_comb begin
    wmask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & {32{we}}; // see (R16)
    rw_new = (st_q.val & ~wmask) | (wdata & wmask);
    // hardware set is or-ed in last so a same-cycle event beats the clear
    w1c_new = (st_q.val & ~(wmask & wdata)) | hw_set; // see (R6) see (R7)
    st_d.val = (rw_new & RW) | (w1c_new & W1C); // see (R8) see (R2)
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{val: RST & (RW | W1C)};
    end else begin
      st_q <= st_d;
    end
  end

  // read-only bits show live hardware, fixed bits their constant, RW and W1C bits the stored value, rest zero
  assign rdata = (st_q.val & (RW | W1C)) | (hw_val & RO) | FIXED_ONE; // see (R1) see (R10)
  assign val_q = st_q.val;

  property p_w1c_set_wins;
    @(posedge clk) disable iff (!resetn)
    ((hw_set & W1C) != 0) |=> ((val_q & $past(hw_set) & W1C) == ($past(hw_set) & W1C));
  endproperty
  a_w1c_set_wins: assert property (p_w1c_set_wins) // see (R7)
    else $error("status event lost against clear");

  property p_w1c_zero_keeps;
    @(posedge clk) disable iff (!resetn)
    (we && be == 4'hF) |=> (((val_q ^ $past(val_q)) & W1C & ~$past(wdata)
      & ~$past(hw_set)) == 0);
  endproperty
  a_w1c_zero_keeps: assert property (p_w1c_zero_keeps) // see (R6)
    else $error("status bit changed by writing zero");
endmodule // regfap_word
`default_nettype wire

// File: testbench/test_register_field_access_policy.sv
// test_register_field_access_policy: self-checking bench for the access port of the bank
`timescale 1ns/1ps
`default_nettype none
module test_register_field_access_policy;
  import regfap_pkg::*;
  logic clk, resetn, acc_valid, acc_write, acc_done, acc_misaligned;
  logic [1:0] acc_size;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata, hw_set, hw_val, acc_rdata, ctrl_q, stat_q, rd, mis;
  int err_total = 0;
  int n_tests = 0;

  regfap_access i_dut (
    .clk(clk), .resetn(resetn), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_size(acc_size), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .hw_set(hw_set),
    .hw_val(hw_val), .acc_done(acc_done), .acc_misaligned(acc_misaligned),
    .acc_rdata(acc_rdata), .ctrl_q(ctrl_q), .stat_q(stat_q)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic end_sim();
    if (err_total == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // entered at a falling edge; leaves valid high so calls run back to back
  task automatic acc(input logic w, input logic [1:0] sz, input logic [4:0] a,
                     input logic [31:0] d);
    acc_valid = 1'b1;
    acc_write = w;
    acc_size = sz;
    acc_addr = a;
    acc_wdata = d;
    @(negedge clk);
    rd = acc_rdata;
    mis = {31'h0, acc_misaligned};
    chk({31'h0, acc_done}, 32'h1);
  endtask

  // done and misaligned stand for one cycle only
  task automatic idle();
    acc_valid = 1'b0;
    @(negedge clk);
    chk({31'h0, acc_done}, 32'h0);
    chk({31'h0, acc_misaligned}, 32'h0);
  endtask

  task automatic hset(input logic [31:0] bits);
    hw_set = bits;
    @(negedge clk);
    hw_set = 32'h0;
  endtask

  task automatic t_ctrl();
    acc(1'b0, SZ_WORD, CTRL_OFF, 32'h0);
    chk(rd, 32'h00FF_0000);
    acc(1'b1, SZ_WORD, CTRL_OFF, 32'hFFFF_FFFF);
    chk(ctrl_q, 32'h0000_FFFF);
    acc(1'b1, SZ_WORD, CTRL_OFF, 32'h0000_0000);
    chk(ctrl_q, 32'h0000_0000);
    acc(1'b1, SZ_HALF, 5'h00, 32'h0000_FFFF);
    acc(1'b1, SZ_BYTE, 5'h01, 32'h0000_00AB);
    chk(ctrl_q, 32'h0000_ABFF);
    acc(1'b0, SZ_HALF, 5'h00, 32'h0);
    chk(rd, 32'h0000_ABFF);
    acc(1'b0, SZ_BYTE, 5'h01, 32'h0);
    chk(rd, 32'h0000_00AB);
    acc(1'b0, SZ_BYTE, 5'h02, 32'h0);
    chk(rd, 32'h0000_00FF);
    acc(1'b0, SZ_BYTE, 5'h03, 32'h0);
    chk(rd, 32'h0000_0000);
    acc(1'b0, SZ_HALF, 5'h02, 32'h0);
    chk(rd, 32'h0000_00FF);
    chk(mis, 32'h0);
    acc(1'b1, SZ_BYTE, 5'h00, 32'h0000_0056);
    chk(ctrl_q, 32'h0000_AB56);
    acc(1'b0, SZ_WORD, CTRL_OFF, 32'h0);
    chk(rd, 32'h00FF_AB56);
    idle();
  endtask

  task automatic t_misaligned();
    acc(1'b1, SZ_HALF, 5'h01, 32'h0000_1234);
    chk(mis, 32'h1);
    chk(ctrl_q, 32'h0000_AB56);
    acc(1'b0, SZ_WORD, 5'h02, 32'h0);
    chk(mis, 32'h1);
    chk(rd, 32'h0);
    acc(1'b1, SZ_WORD, 5'h02, 32'hFFFF_FFFF);
    chk(mis, 32'h1);
    chk(ctrl_q, 32'h0000_AB56);
    acc(1'b1, 2'h3, 5'h00, 32'hFFFF_FFFF);
    chk(mis, 32'h1);
    chk(ctrl_q, 32'h0000_AB56);
    idle();
  endtask

  task automatic t_w1c();
    hset(32'h0000_000F);
    chk(stat_q, 32'h0000_000F);
    acc(1'b0, SZ_WORD, STAT_OFF, 32'h0);
    chk(rd, 32'h0000_000F);
    idle();
    hset(32'h0000_0010);
    acc(1'b1, SZ_WORD, STAT_OFF, rd);
    chk(stat_q, 32'h0000_0010);
    acc(1'b1, SZ_WORD, STAT_OFF, 32'h0);
    chk(stat_q, 32'h0000_0010);
    acc(1'b1, SZ_BYTE, 5'h05, 32'h0000_00FF);
    chk(stat_q, 32'h0000_0010);
    // a set landing with the clear must survive
    hw_set = 32'h0000_0010;
    acc(1'b1, SZ_BYTE, 5'h04, 32'h0000_0010);
    hw_set = 32'h0;
    chk(stat_q, 32'h0000_0010);
    acc(1'b1, SZ_BYTE, 5'h04, 32'h0000_0010);
    chk(stat_q, 32'h0000_0000);
    idle();
  endtask

  task automatic t_ro_rsv();
    hw_val = 32'hA5A5_5A5A;
    acc(1'b1, SZ_WORD, HWST_OFF, 32'hFFFF_FFFF);
    acc(1'b0, SZ_WORD, HWST_OFF, 32'h0);
    chk(rd, 32'h0000_5A5A);
    hw_val = 32'h0000_C3C3;
    acc(1'b0, SZ_BYTE, 5'h09, 32'h0);
    chk(rd, 32'h0000_00C3);
    acc(1'b1, SZ_WORD, RSV_OFF, 32'hFFFF_FFFF);
    acc(1'b0, SZ_WORD, RSV_OFF, 32'h0);
    chk(rd, 32'h0);
    chk(mis, 32'h0);
    acc(1'b1, SZ_WORD, 5'h10, 32'hFFFF_FFFF);
    acc(1'b0, SZ_WORD, 5'h1C, 32'h0);
    chk(rd, 32'h0);
    chk(ctrl_q, 32'h0000_AB56);
    idle();
  endtask

  // software side: read the whole word, change one field, write it all back
  task automatic t_rmw();
    logic [31:0] v;
    acc(1'b0, SZ_WORD, CTRL_OFF, 32'h0);
    v = (rd & 32'hFFFF_00FF) | 32'h0000_3C00;
    acc(1'b1, SZ_WORD, CTRL_OFF, v);
    chk(ctrl_q, 32'h0000_3C56);
    acc(1'b0, SZ_WORD, CTRL_OFF, 32'h0);
    chk(rd, 32'h00FF_3C56);
    idle();
  endtask

  initial begin
    resetn = 1'b0;
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_size = 2'h0;
    acc_addr = 5'h00;
    acc_wdata = 32'h0;
    hw_set = 32'h0;
    hw_val = 32'h0;
    repeat (20) @(negedge clk);
    chk(ctrl_q | stat_q | acc_rdata, 32'h0);
    resetn = 1'b1;
    @(negedge clk);
    t_ctrl();
    t_misaligned();
    t_w1c();
    t_ro_rsv();
    t_rmw();
    end_sim();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    #80000;
    err_total++;
    end_sim();
  end
endmodule // test_register_field_access_policy
`default_nettype wire
